// file: src/sarct_pkg.sv
// sarct_pkg: shared constants and types for the converter timing block
package sarct_pkg;
    // ----------------------------------------------------------------
    // clock, word size and fifo depth
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;

    // cycles from a time: floor for a longest time, ceil for a least time
    function automatic int cyc_floor(input int ns);
        return (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
    endfunction
    function automatic int cyc_ceil(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // ----------------------------------------------------------------
    // conversion timing (busy high, result valid)
    // ----------------------------------------------------------------
    localparam int WARP_CONV_NS = 750;
    localparam int NORMAL_CONV_NS = 1000;
    localparam int IMPULSE_CONV_NS = 1250;
    // busy edge, push and data register sit around the core count
    localparam int CONV_OVERHEAD_CYC = 3;
    localparam logic [5:0] WARP_CONV_CYC = 6'(cyc_floor(WARP_CONV_NS) - CONV_OVERHEAD_CYC);
    localparam logic [5:0] NORMAL_CONV_CYC = 6'(cyc_floor(NORMAL_CONV_NS) - CONV_OVERHEAD_CYC);
    localparam logic [5:0] IMPULSE_CONV_CYC = 6'(cyc_floor(IMPULSE_CONV_NS) - CONV_OVERHEAD_CYC);

    // ----------------------------------------------------------------
    // master serial timing
    // ----------------------------------------------------------------
    // start to frame marker in read-during-convert (typical, rounded)
    localparam int WARP_SYNC_NS = 25;
    localparam int NORMAL_SYNC_NS = 275;
    localparam int IMPULSE_SYNC_NS = 525;
    localparam logic [3:0] WARP_SYNC_CYC = 4'(cyc_ceil(WARP_SYNC_NS));
    localparam logic [3:0] NORMAL_SYNC_CYC = 4'((NORMAL_SYNC_NS + 20) / CLK_PERIOD_NS);
    localparam logic [3:0] IMPULSE_SYNC_CYC = 4'((IMPULSE_SYNC_NS + 20) / CLK_PERIOD_NS);
    // longest serial clock period per divider setting
    localparam int SCLK_MAX_NS [4] = '{40, 70, 140, 280};
    // marker to first edge, least (17 ns covers all settings)
    localparam int LEAD_NS = 17;
    localparam logic [3:0] LEAD_CYC = 4'(cyc_ceil(LEAD_NS));
    // last edge to marker change, least, per divider setting
    localparam int TAIL_NS [4] = '{3, 55, 130, 290};
    // marker drop to busy low
    localparam int BUSY_END_NS = 25;
    localparam logic [3:0] BUSY_END_CYC = 4'(cyc_ceil(BUSY_END_NS));

    function automatic logic [3:0] sclk_cyc(input logic [1:0] div);
        int p;
        p = cyc_floor(SCLK_MAX_NS[div]);
        return (p < 2) ? 4'h2 : 4'(p);
    endfunction
    function automatic logic [3:0] tail_cyc(input logic [1:0] div);
        return 4'(cyc_ceil(TAIL_NS[div]));
    endfunction

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SARCT_WARP = 2'b00,
        SARCT_NORMAL = 2'b01,
        SARCT_IMPULSE = 2'b10
    } sarct_speed_t;

    // raw input pins, all from outside the clock domain
    typedef struct packed {
        logic convert_start_n;
        logic chip_select_n;
        logic read_n;
        logic ext_sclk;
        logic serial_chain_in;
        logic serial_select;
        logic ext_clock_select;
        logic read_during_select;
        logic warp_select;
        logic impulse_select;
        logic byte_order_select;
        logic output_coding_select;
        logic [1:0] clock_divider_select;
    } sarct_pins_t;
    localparam int PIN_W = $bits(sarct_pins_t);
    localparam sarct_pins_t PIN_IDLE = '{convert_start_n: 1'b1, chip_select_n: 1'b1,
        read_n: 1'b1, default: '0};
endpackage

// file: src/sarct_top.sv
// sarct_top: conversion sequencing and result readout of the converter
`timescale 1ns/1ps
// Notes on behaviour
// R1 - host spaces start pulses per speed mode
// R2 - fastest mode: restart within one millisecond
// R3 - busy rises promptly after start falls
// R4 - busy high bounded per speed mode
// R5 - parallel result valid within conversion time
// R6 - parallel data valid before busy falls
// R7 - frame marker driven once chip select low
// R8 - serial output released when chip select high
// R9 - marker delayed per mode in read-during
// R10 - master clock period follows divider setting (read-during ignores it and uses setting 0)
// R11 - least gap marker to first clock edge
// R12 - least gap last edge to marker change
// R13 - fastest mode read-after busy bound
// R14 - normal mode read-after busy bound
// R15 - power-scaled read-after busy bound
// R16 - busy falls shortly after marker drops
// R17 - slave data updates on active edge
// R18 - byte order input swaps parallel bytes
// R19 - coding input inverts msb for twos
// R20 - whole word ready at conversion end
// R21 - host holds mode inputs stable meanwhile
// ----------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------
module sarct_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sarct_fifo_st_t;
    sarct_fifo_st_t r;
    sarct_fifo_st_t next_r;
    logic push;
    logic pop;
    // honest flags straight from the count
    assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o = r.mem[r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // pointer and count update
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data_i;
            next_r.wp = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (sys_rst_i) begin
            next_r.wp = '0;
            next_r.rp = '0;
            next_r.cnt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        r <= next_r;
    end
endmodule
// ----------------------------------------------------------------
// sequencing and readout
// ----------------------------------------------------------------
module sarct_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // host pins, asynchronous to clk_i
    input wire sarct_pkg::sarct_pins_t pins_i,
    // converter core result
    input wire logic [15:0] core_result_i,
    // status
    output logic busy_o,
    output logic fifo_full_o,
    // parallel bus
    output logic [15:0] data_o,
    output logic data_oe_n_o,
    // serial port
    output logic serial_data_out,
    output logic serial_data_oe_n_o,
    output logic sync_o,
    output logic sync_oe_n_o,
    output logic sclk_o,
    output logic sclk_oe_n_o
);
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_CONV = 3'b001,
        C_PUSH = 3'b010,
        C_WAIT = 3'b011,
        C_END = 3'b100
    } sarct_conv_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_LEAD = 2'b01,
        S_SHIFT = 2'b10,
        S_TAIL = 2'b11
    } sarct_ser_t;
    typedef struct packed {
        sarct_pkg::sarct_pins_t s1;
        sarct_pkg::sarct_pins_t s2;
        sarct_pkg::sarct_pins_t s3;
        sarct_pkg::sarct_pins_t filt;
        sarct_conv_t cst;
        logic [5:0] ccnt;
        logic busy;
        logic rdc_arm;
        logic [3:0] rdc_cnt;
        sarct_ser_t sst;
        logic [1:0] sdiv;
        logic [4:0] bits;
        logic [3:0] tcnt;
        logic [15:0] shreg;
        logic sclk;
        logic sync;
        logic sdo;
        logic [15:0] pdata;
        logic [4:0] sbits;
    } sarct_st_t;
    sarct_st_t r;
    sarct_st_t n;
    logic [sarct_pkg::PIN_W-1:0] filt_next;
    sarct_pkg::sarct_pins_t f;
    sarct_pkg::sarct_speed_t speed;
    logic par;
    logic slave;
    logic m_rdc;
    logic m_rac;
    logic cnv_fall;
    logic ext_rise;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_word;
    logic [15:0] coded;
    logic ser_start;
    logic slave_load;
    // a pin change counts once the second and third stages agree
    for (genvar i = 0; i < sarct_pkg::PIN_W; i++) begin : g_pin
        assign filt_next[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i];
    end
    // decoded modes from the filtered pins, held stable by the host
    assign f = r.filt; // R21
    assign par = !f.serial_select;
    assign slave = f.serial_select && f.ext_clock_select;
    assign m_rdc = f.serial_select && !f.ext_clock_select && f.read_during_select;
    assign m_rac = f.serial_select && !f.ext_clock_select && !f.read_during_select;
    assign speed = f.impulse_select ? sarct_pkg::SARCT_IMPULSE :
        (f.warp_select ? sarct_pkg::SARCT_WARP : sarct_pkg::SARCT_NORMAL);
    assign cnv_fall = f.convert_start_n && !filt_next[sarct_pkg::PIN_W-1];
    assign ext_rise = !f.ext_sclk && filt_next[sarct_pkg::PIN_W-4];
    // msb inverted for twos complement when the coding pin is low
    assign coded = {core_result_i[15] ^ !f.output_coding_select, core_result_i[14:0]}; // R19
    // who takes the fifo head
    assign ser_start = (r.sst == S_IDLE) && fifo_out_valid &&
        ((m_rac && r.cst == C_WAIT) || (m_rdc && r.rdc_arm && r.rdc_cnt == 4'h0));
    assign slave_load = slave && fifo_out_valid && r.sbits == 5'h0 && f.chip_select_n;
    assign fifo_out_ready = par || ser_start || slave_load;
    // a full fifo refuses new conversions, stalling the sequencer
    sarct_fifo #(
        .WIDTH(sarct_pkg::WORD_W),
        .DEPTH(sarct_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(r.cst == C_PUSH),
        .in_ready_o(fifo_in_ready),
        .in_data_i(coded), // R20
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_word)
    );
    // next state of the whole block
    always_comb begin
        n = r;
        n.s1 = pins_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = sarct_pkg::sarct_pins_t'(filt_next);
        // conversion sequencer
        unique case (r.cst)
            C_IDLE: begin
                if (cnv_fall && fifo_in_ready) begin
                    n.busy = 1'b1; // R3
                    n.cst = C_CONV;
                    unique case (speed)
                        sarct_pkg::SARCT_WARP: n.ccnt = sarct_pkg::WARP_CONV_CYC; // R4
                        sarct_pkg::SARCT_NORMAL: n.ccnt = sarct_pkg::NORMAL_CONV_CYC;
                        default: n.ccnt = sarct_pkg::IMPULSE_CONV_CYC;
                    endcase
                    n.rdc_arm = m_rdc;
                    unique case (speed)
                        sarct_pkg::SARCT_WARP: n.rdc_cnt = sarct_pkg::WARP_SYNC_CYC; // R9
                        sarct_pkg::SARCT_NORMAL: n.rdc_cnt = sarct_pkg::NORMAL_SYNC_CYC;
                        default: n.rdc_cnt = sarct_pkg::IMPULSE_SYNC_CYC;
                    endcase
                end
            end
            C_CONV: begin
                n.ccnt = r.ccnt - 6'h01;
                if (r.ccnt == 6'h01) begin
                    n.cst = C_PUSH;
                end
            end
            C_PUSH: begin
                n.cst = C_WAIT;
            end
            C_WAIT: begin
                // read-after holds busy over the whole transfer
                if (!m_rac) begin
                    n.cst = C_END; // R6
                end else if (r.sst == S_TAIL && r.tcnt == 4'h1) begin
                    n.cst = C_END; // R16
                end
            end
            C_END: begin
                n.busy = 1'b0; // R13 R14 R15
                n.cst = C_IDLE;
            end
            default: n.cst = C_IDLE;
        endcase
        // read-during delay from the start edge to the marker
        if (r.rdc_arm) begin
            if (r.rdc_cnt != 4'h0) begin
                n.rdc_cnt = r.rdc_cnt - 4'h1;
            end else begin
                n.rdc_arm = 1'b0;
            end
        end
        // parallel bus takes every result at once
        if (par && fifo_out_valid) begin
            n.pdata = f.byte_order_select ? {fifo_word[7:0], fifo_word[15:8]} : fifo_word; // R18 R5
        end
        // master serial engine, data changes on the falling edge
        unique case (r.sst)
            S_IDLE: begin
                if (ser_start) begin
                    n.sst = S_LEAD;
                    n.sync = 1'b1;
                    n.shreg = fifo_word;
                    n.sdo = fifo_word[15];
                    n.sdiv = m_rdc ? 2'b00 : f.clock_divider_select;
                    n.tcnt = sarct_pkg::LEAD_CYC; // R11
                    n.bits = 5'h10;
                end
            end
            S_LEAD: begin
                n.tcnt = r.tcnt - 4'h1;
                if (r.tcnt == 4'h1) begin
                    n.sst = S_SHIFT;
                    n.tcnt = sarct_pkg::sclk_cyc(r.sdiv) - (sarct_pkg::sclk_cyc(r.sdiv) >> 1);
                end
            end
            S_SHIFT: begin
                n.tcnt = r.tcnt - 4'h1;
                if (r.tcnt == 4'h1) begin
                    if (!r.sclk) begin
                        n.sclk = 1'b1;
                        n.tcnt = sarct_pkg::sclk_cyc(r.sdiv) >> 1; // R10
                    end else begin
                        n.sclk = 1'b0;
                        n.bits = r.bits - 5'h01;
                        if (r.bits == 5'h01) begin
                            n.sst = S_TAIL;
                            n.tcnt = sarct_pkg::tail_cyc(r.sdiv); // R12
                        end else begin
                            n.shreg = {r.shreg[14:0], 1'b0};
                            n.sdo = r.shreg[14];
                            n.tcnt = sarct_pkg::sclk_cyc(r.sdiv) -
                                (sarct_pkg::sclk_cyc(r.sdiv) >> 1);
                        end
                    end
                end
            end
            S_TAIL: begin
                n.tcnt = r.tcnt - 4'h1;
                if (r.tcnt == 4'h1) begin
                    n.sync = 1'b0;
                    n.sst = S_IDLE;
                end
            end
        endcase
        // slave port: load when idle, shift the chain input in behind
        if (slave_load) begin
            n.shreg = fifo_word;
            n.sdo = fifo_word[15];
            n.sbits = 5'h10;
        end else if (slave && ext_rise && !f.chip_select_n) begin
            n.shreg = {r.shreg[14:0], f.serial_chain_in};
            n.sdo = r.shreg[14]; // R17
            if (r.sbits != 5'h0) begin
                n.sbits = r.sbits - 5'h01;
            end
        end
        // synchronous reset; pins start at their idle levels
        if (sys_rst_i) begin
            n = '0; // idle states both encode as zero
            n.s1 = sarct_pkg::PIN_IDLE;
            n.s2 = sarct_pkg::PIN_IDLE;
            n.s3 = sarct_pkg::PIN_IDLE;
            n.filt = sarct_pkg::PIN_IDLE;
        end
    end
    always_ff @(posedge clk_i) begin
        r <= n;
    end
    // outputs; enables follow the filtered chip select and read
    assign busy_o = r.busy;
    assign fifo_full_o = !fifo_in_ready;
    assign data_o = r.pdata;
    assign data_oe_n_o = !(par && !f.chip_select_n && !f.read_n);
    assign serial_data_out = r.sdo;
    assign serial_data_oe_n_o = !f.serial_select || f.chip_select_n; // R8
    assign sync_o = r.sync;
    assign sync_oe_n_o = slave || !f.serial_select || f.chip_select_n; // R7
    assign sclk_o = r.sclk;
    assign sclk_oe_n_o = slave || !f.serial_select || f.chip_select_n;
endmodule

// file: bench/sarct_top_assertions.sv
// checker: port timing assertions for sarct_top
`timescale 1ns/1ps
module sarct_top_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // inputs of the block
    input wire sarct_pkg::sarct_pins_t pins_i,
    input wire logic [15:0] core_result_i,
    // outputs of the block
    input wire logic busy_o,
    input wire logic fifo_full_o,
    input wire logic [15:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n_o,
    input wire logic sync_o,
    input wire logic sync_oe_n_o,
    input wire logic sclk_o,
    input wire logic sclk_oe_n_o
);
    // ----------------------------------------
    // mode decode and expected figures
    // ----------------------------------------
    logic par;
    logic mst;
    logic ra;
    logic sclk_q;
    logic [7:0] per_cnt;
    logic [7:0] lo_cnt;
    logic [7:0] busy_cnt;
    logic [7:0] per_exp;
    logic [7:0] busy_exp;
    logic [15:0] word_exp;
    assign par = !pins_i.serial_select;
    assign mst = pins_i.serial_select && !pins_i.ext_clock_select;
    assign ra = mst && !pins_i.read_during_select;
    // modes are held stable by the host, so raw pins serve as the mode
    always_comb begin
        per_exp = pins_i.clock_divider_select[1] ? 8'h03 : 8'h02;
        if (pins_i.clock_divider_select == 2'h3) begin
            per_exp = 8'h07;
        end
        busy_exp = pins_i.warp_select ? 8'h12 : 8'h19;
        if (pins_i.impulse_select) begin
            busy_exp = 8'h1f;
        end
        word_exp = {core_result_i[15] ^ !pins_i.output_coding_select, core_result_i[14:0]};
        if (pins_i.byte_order_select) begin
            word_exp = {word_exp[7:0], word_exp[15:8]};
        end
    end
    // saturating counters: a wrap would fake a short period
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_q <= 1'b0;
            per_cnt <= 8'hff;
            lo_cnt <= 8'h00;
            busy_cnt <= 8'h00;
        end else begin
            sclk_q <= sclk_o;
            per_cnt <= (sclk_o && !sclk_q) ? 8'h01 : per_cnt + 8'(per_cnt != 8'hff);
            lo_cnt <= sclk_o ? 8'h00 : lo_cnt + 8'(lo_cnt != 8'hff);
            busy_cnt <= busy_o ? busy_cnt + 8'(busy_cnt != 8'hff) : 8'h00;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_busy_rise: assert property ($rose(busy_o) |-> !$past(pins_i.convert_start_n, 3))
        else $error("busy rose without a start pulse");
    chk_busy_width: assert property ($fell(busy_o) && !ra |-> busy_cnt == busy_exp)
        else $error("busy high time wrong for speed mode");
    chk_data_settled: assert property ($fell(busy_o) && par |-> $stable(data_o))
        else $error("parallel data changed as busy fell");
    chk_par_word: assert property ($fell(busy_o) && par |-> data_o == word_exp)
        else $error("parallel word wrong at end of conversion");
    chk_sync_drive: assert property ((!pins_i.chip_select_n && mst)[*5] |=>
        !sync_oe_n_o && !sclk_oe_n_o)
        else $error("marker not driven with select low");
    chk_serial_release: assert property (pins_i.chip_select_n[*5] |=>
        serial_data_oe_n_o && sync_oe_n_o && sclk_oe_n_o && data_oe_n_o)
        else $error("outputs not released with select high");
    chk_sclk_period: assert property (sclk_o && !sclk_q && ra && per_cnt < 8'h10 |->
        per_cnt == per_exp)
        else $error("serial clock period wrong");
    chk_sync_lead: assert property ($rose(sync_o) && mst |-> !sclk_o ##1 !sclk_o)
        else $error("serial clock edge too close to marker");
    chk_sync_tail: assert property ($fell(sync_o) && ra |->
        lo_cnt >= (8'h01 << pins_i.clock_divider_select))
        else $error("marker dropped too soon after last edge");
    chk_busy_after: assert property ($fell(sync_o) && ra |=> $fell(busy_o))
        else $error("busy did not follow marker drop");
    cov_par: cover property ($fell(busy_o) && par);
    cov_frame: cover property ($fell(sync_o) && ra);
    cov_full: cover property ($rose(fifo_full_o));
endmodule

// file: bench/sarct_host_model.sv
// host model: captures master frames and clocks slave reads
`timescale 1ns/1ps
module sarct_host_model (
    // clock
    input wire logic clk_i,
    // device serial pins
    input wire logic sclk_i,
    input wire logic sync_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i,
    // host driven pins
    output logic ext_sclk_o,
    output logic cs_n_o,
    // last captured master frame
    output logic [15:0] word_o,
    output logic [7:0] n_words_o
);
    logic sclk_q = 1'b0;
    logic sync_q = 1'b0;
    logic [15:0] shift = 16'h0000;
    initial begin
        ext_sclk_o = 1'b0;
        cs_n_o = 1'b1;
        word_o = 16'h0000;
        n_words_o = 8'h00;
    end
    // master: data moves on the fall, so take it on the rise
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        sync_q <= sync_i;
        if (sclk_i && !sclk_q && !sdo_oe_n_i) begin
            shift <= {shift[14:0], sdo_i};
        end
        if (sync_q && !sync_i) begin
            word_o <= shift;
            n_words_o <= n_words_o + 8'h01;
        end
    end
    // slave: slow clock, idle low between frames, bit read before each rise
    task automatic read_slave(output logic [15:0] w);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], sdo_i};
            ext_sclk_o <= 1'b1;
            repeat (5) @(posedge clk_i);
            ext_sclk_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// file: bench/sarct_top_tb.sv
// testbench for sarct_top: conversions in every readout mode
`timescale 1ns/1ps
module sarct_top_tb;
    // ----------------------------------------
    // clock, pins and counters
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    sarct_pkg::sarct_pins_t pins = sarct_pkg::PIN_IDLE;
    sarct_pkg::sarct_pins_t pin_bus;
    logic [15:0] core = 16'h0000;
    logic busy_o, fifo_full_o, data_oe_n_o, sdo, sdo_oe_n, sync_o, sclk_o, h_sclk, h_cs_n, b;
    logic [15:0] data_o, h_word, v, w, e;
    logic [7:0] h_cnt, cnt;
    logic [15:0] q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    // host clock and select come from the model
    always_comb begin
        pin_bus = pins;
        pin_bus.ext_sclk = h_sclk;
        pin_bus.chip_select_n = pins.chip_select_n & h_cs_n;
    end
    sarct_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pin_bus),
        .core_result_i(core), .busy_o(busy_o), .fifo_full_o(fifo_full_o), .data_o(data_o),
        .data_oe_n_o(data_oe_n_o), .serial_data_out(sdo), .serial_data_oe_n_o(sdo_oe_n),
        .sync_o(sync_o), .sync_oe_n_o(), .sclk_o(sclk_o), .sclk_oe_n_o());
    sarct_host_model i_host (.clk_i(clk_i), .sclk_i(sclk_o), .sync_i(sync_o), .sdo_i(sdo),
        .sdo_oe_n_i(sdo_oe_n), .ext_sclk_o(h_sclk), .cs_n_o(h_cs_n), .word_o(h_word),
        .n_words_o(h_cnt));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] coded(input logic [15:0] x);
        return {x[15] ^ ~pins.output_coding_select, x[14:0]};
    endfunction
    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // start pulse held 4 cycles so a slow filter still sees it
    task automatic convert(input logic [15:0] x, input logic acc);
        @(posedge clk_i);
        core <= x;
        pins.convert_start_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins.convert_start_n <= 1'b1;
        @(negedge clk_i); // busy is launched on the last rising edge, so look mid-cycle
        b = busy_o;
        check({15'h0, b}, {15'h0, acc});
        while (busy_o === 1'b1) @(posedge clk_i);
        repeat (10) @(posedge clk_i);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h2a3460f3));
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        pins.chip_select_n <= 1'b0;
        pins.read_n <= 1'b0;
        // parallel: every speed, random coding and byte order, corner words first
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : (i == 2) ? 16'h8000 : 16'($urandom);
            pins.warp_select <= (i % 3 == 0);
            pins.impulse_select <= (i % 3 == 2);
            pins.output_coding_select <= 1'($urandom);
            pins.byte_order_select <= 1'($urandom);
            repeat (6) @(posedge clk_i);
            convert(v, 1'b1);
            e = coded(v);
            check(data_o, pins.byte_order_select ? {e[7:0], e[15:8]} : e);
            check({15'h0, data_oe_n_o}, 16'h0000);
        end
        // master read-after-convert, every divider setting
        pins.serial_select <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            v = 16'($urandom);
            pins.clock_divider_select <= 2'(d);
            repeat (6) @(posedge clk_i);
            cnt = h_cnt;
            convert(v, 1'b1);
            check(h_word, coded(v));
            check({8'h00, h_cnt}, {8'h00, cnt + 8'h01});
        end
        // slave: fill the buffer unread until it refuses, then drain it
        pins.ext_clock_select <= 1'b1;
        pins.chip_select_n <= 1'b1;
        pins.serial_chain_in <= 1'($urandom);
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < 20 && fifo_full_o !== 1'b1; i++) begin
            v = 16'($urandom);
            convert(v, 1'b1);
            q.push_back(coded(v));
        end
        check({15'h0, fifo_full_o}, 16'h0001);
        convert(16'h5a5a, 1'b0);
        while (q.size() > 0) begin
            i_host.read_slave(w);
            check(w, q.pop_front());
        end
        check({15'h0, fifo_full_o}, 16'h0000);
        // master read-during-convert sends the previous result
        pins.ext_clock_select <= 1'b0;
        pins.read_during_select <= 1'b1;
        pins.chip_select_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        v = 16'($urandom);
        convert(v, 1'b1);
        e = coded(v);
        cnt = h_cnt;
        convert(16'($urandom), 1'b1);
        for (int k = 0; k < 100 && h_cnt == cnt; k++) @(posedge clk_i);
        check(h_word, e);
        close_out();
    end
    // hang guard well beyond the few thousand cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
endmodule
bind sarct_top sarct_top_assertions i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pins_i(pins_i), .core_result_i(core_result_i), .busy_o(busy_o),
    .fifo_full_o(fifo_full_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .serial_data_out(serial_data_out), .serial_data_oe_n_o(serial_data_oe_n_o),
    .sync_o(sync_o), .sync_oe_n_o(sync_oe_n_o), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o));
